/* rtl/vic_pkg.sv */
// Purpose: Constants and types of the vectored interrupt controller
// Assumes: Word-indexed registers on a 32-bit AHB-Lite bus
// Notes:   Byte address of a register is four times its index
package vic_pkg;

  // ==========================================================
  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_CPU_STATUS  = 8'h06;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h07;
  localparam logic [7:0] IDX_PFLAG_B     = 8'h10;
  localparam logic [7:0] IDX_PENABLE_B   = 8'h11;
  localparam logic [7:0] IDX_PFLAG_A     = 8'h16;
  localparam logic [7:0] IDX_PENABLE_A   = 8'h17;
  localparam int         IDX_LSB         = 2;
  localparam int         IDX_MSB         = 9;

  // ==========================================================
  // irq_status_ctrl fields
  localparam int ST_PEND  = 7;
  localparam int ST_CKF   = 6;
  localparam int ST_T0F   = 5;
  localparam int ST_EXTF  = 4;
  localparam int ST_PERIPH_IRQ_ENABLE  = 3;
  localparam int ST_CKE   = 2;
  localparam int ST_T0E   = 1;
  localparam int ST_EXTE  = 0;
  localparam logic [3:0] ST_EN_RST = 4'h0;

  // ==========================================================
  // cpu_status_reg fields
  localparam int CS_GD       = 4;
  localparam int CS_EXT_RISE = 1;
  localparam int CS_CK_RISE  = 0;
  localparam logic       GD_RST       = 1'b1;
  localparam logic [1:0] EDGE_SEL_RST = 2'h3;

  // ==========================================================
  // Widths, counts, vectors
  localparam int NUM_SOURCES = 18;
  localparam int PA_W        = 8;
  localparam int PB_W        = 7;
  localparam int PC_W        = 16;
  localparam int STACK_DEPTH = 16;
  localparam int SP_W        = 4;
  localparam logic [PA_W-1:0] PA_RST = 8'h00;
  localparam logic [PB_W-1:0] PB_RST = 7'h00;
  localparam logic [PC_W-1:0] VEC_RESET  = 16'h0000;
  localparam logic [PC_W-1:0] VEC_EXT    = 16'h0008;
  localparam logic [PC_W-1:0] VEC_T0     = 16'h0010;
  localparam logic [PC_W-1:0] VEC_CK     = 16'h0018;
  localparam logic [PC_W-1:0] VEC_PERIPH = 16'h0020;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    VS_NONE   = 3'h0,
    VS_EXT    = 3'h1,
    VS_T0     = 3'h3,
    VS_CK     = 3'h2,
    VS_PER    = 3'h6,
    VS_RESET  = 3'h7
  } vec_sel_e;

  // Peripheral event pulses; upper 8 map to flag reg A, lower 7 to B
  typedef struct packed {
    logic portChange;
    logic tmr3Ovf;
    logic tmr2Ovf;
    logic tmr1Ovf;
    logic capture2;
    logic capture1;
    logic serial1TxEmpty;
    logic serial1RxFull;
    logic sspEvent;
    logic busCollision;
    logic convDone;
    logic capture4;
    logic capture3;
    logic serial2TxEmpty;
    logic serial2RxFull;
  } periph_evt_s;

  typedef struct packed {
    logic            load;
    logic [PC_W-1:0] addr;
  } pc_load_s;

endpackage

/* rtl/vic_irq_ctrl.sv */
// Purpose: Vectored interrupt controller for an 8-bit core
// Assumes: Core acks only on instruction boundaries, same clock
// Notes:   AHB-Lite slave, zero wait states, always OKAY
//
// Function
// - Eighteen sources collected into flags
// - Global disable blocks every core request
// - Entry sets disable, pushes, loads vector
// - Four vectors, peripherals share one
// - External pin to 08h, clears its flag
// - Timer zero overflow to 10h, clears flag
// - Clock pin edge to 18h, clears flag
// - Peripherals to 20h, flags untouched
// - Flags set regardless of any enable
// - Pin events have latency, longer mid-instruction
// - Return pops address, clears global disable
// - Pending flag is enabled-peripheral OR, read-only
// - Enable cleared as flag sets: vector 00h
// - Peripheral enable gates all peripheral requests
// - Status register at 07h, fields, zero reset
// - Selected pin edges set edge flags
// - Timer zero flag set on overflow or by software write
// - Non-peripheral request needs flag, enable, no-disable
// - Two peripheral enable registers, zero reset
`timescale 1ns/10ps

module vic_irq_ctrl (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  // Pins, asynchronous
  input  wire logic                        extIrqPin,
  input  wire logic                        timerClockPin,
  // Event pulses from peripherals
  input  wire logic                        timer0Ovf,
  input  wire vic_pkg::periph_evt_s        periphEvt,
  // Core sequencer
  input  wire logic                        irqAck,
  input  wire logic                        returnFromIrqInstr,
  input  wire logic [vic_pkg::PC_W-1:0]    pcReturn,
  output logic                             irqReq,
  output vic_pkg::pc_load_s                pcLoad,
  output logic                             globalIrqDisable
);

  // ==========================================================
  // Declarations
  logic [1:0]                  pinSync1_q;
  logic [1:0]                  pinSync2_q;
  logic [1:0]                  pinPrev_q;
  logic [1:0]                  edgeSel_q;
  logic [1:0]                  pinEdge;
  logic                        gd_q;
  logic                        extFlag_q;
  logic                        t0Flag_q;
  logic                        ckFlag_q;
  logic [3:0]                  stEn_q;
  logic [vic_pkg::PA_W-1:0]    pFlagA_q;
  logic [vic_pkg::PB_W-1:0]    pFlagB_q;
  logic [vic_pkg::PA_W-1:0]    pEnA_q;
  logic [vic_pkg::PB_W-1:0]    pEnB_q;
  logic                        pendFlag;
  logic                        spurious_q;
  vic_pkg::vec_sel_e           vecSel;
  vic_pkg::vec_sel_e           vecSel_q;
  logic [vic_pkg::PC_W-1:0]    stack_q [vic_pkg::STACK_DEPTH];
  logic [vic_pkg::SP_W-1:0]    sp_q;
  logic                        wrPend_q;
  logic [7:0]                  wrIdx_q;
  logic                        addrPhase;
  logic [7:0]                  curIdx;
  logic                        wrStatus;
  logic                        wrCpu;
  logic                        wrPfA;
  logic                        wrPfB;
  logic                        wrPeA;
  logic                        wrPeB;
  logic [7:0]                  wByte;
  logic                        take;
  logic                        enClrHit;

  // ==========================================================
  // Pin synchronisers and edge detect
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pinSync1_q <= 2'h0;
      pinSync2_q <= 2'h0;
      pinPrev_q  <= 2'h0;
    end else begin
      pinSync1_q <= {timerClockPin, extIrqPin};
      pinSync2_q <= pinSync1_q;
      pinPrev_q  <= pinSync2_q;
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pinEdge[i] = edgeSel_q[i] ? (pinSync2_q[i] & ~pinPrev_q[i])
                                : (~pinSync2_q[i] & pinPrev_q[i]);
    end
  end

  // ==========================================================
  // Bus decode; write applies in the data phase
  assign addrPhase = hsel & hready & (htrans == vic_pkg::HTRANS_NONSEQ || htrans == vic_pkg::HTRANS_SEQ);
  assign curIdx    = haddr[vic_pkg::IDX_MSB:vic_pkg::IDX_LSB];
  assign wByte     = hwdata[7:0];
  assign wrStatus  = wrPend_q & (wrIdx_q == vic_pkg::IDX_IRQ_STATUS);
  assign wrCpu     = wrPend_q & (wrIdx_q == vic_pkg::IDX_CPU_STATUS);
  assign wrPfA     = wrPend_q & (wrIdx_q == vic_pkg::IDX_PFLAG_A);
  assign wrPfB     = wrPend_q & (wrIdx_q == vic_pkg::IDX_PFLAG_B);
  assign wrPeA     = wrPend_q & (wrIdx_q == vic_pkg::IDX_PENABLE_A);
  assign wrPeB     = wrPend_q & (wrIdx_q == vic_pkg::IDX_PENABLE_B);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPend_q <= 1'b0;
      wrIdx_q  <= 8'h00;
    end else begin
      wrPend_q <= addrPhase & hwrite;
      wrIdx_q  <= curIdx;
    end
  end

  // Zero wait states; the slave never stretches a transfer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp     <= vic_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= vic_pkg::HRESP_OKAY;
    end
  end

  // Read data sampled at the end of the address phase; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase & ~hwrite) begin
      unique case (curIdx)
        vic_pkg::IDX_IRQ_STATUS: hrdata <= {24'h000000, pendFlag, ckFlag_q, t0Flag_q, extFlag_q, stEn_q};
        vic_pkg::IDX_CPU_STATUS: hrdata <= {27'h0000000, gd_q, 2'h0, edgeSel_q[0], edgeSel_q[1]};
        vic_pkg::IDX_PFLAG_A:    hrdata <= {24'h000000, pFlagA_q};
        vic_pkg::IDX_PFLAG_B:    hrdata <= {25'h0000000, pFlagB_q};
        vic_pkg::IDX_PENABLE_A:  hrdata <= {24'h000000, pEnA_q};
        vic_pkg::IDX_PENABLE_B:  hrdata <= {25'h0000000, pEnB_q};
        default:                 hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Enables and edge selects
  // software-written enables, zero reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stEn_q    <= vic_pkg::ST_EN_RST;
      pEnA_q    <= vic_pkg::PA_RST;
      pEnB_q    <= vic_pkg::PB_RST;
      edgeSel_q <= vic_pkg::EDGE_SEL_RST;
    end else begin
      if (wrStatus) begin
        stEn_q <= wByte[3:0];
      end
      if (wrPeA) begin
        pEnA_q <= wByte;
      end
      if (wrPeB) begin
        pEnB_q <= wByte[vic_pkg::PB_W-1:0];
      end
      if (wrCpu) begin
        edgeSel_q <= {wByte[vic_pkg::CS_CK_RISE], wByte[vic_pkg::CS_EXT_RISE]};
      end
    end
  end

  // ==========================================================
  // Non-peripheral flags; set wins over any clear
  assign take = irqAck & irqReq;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      extFlag_q <= 1'b0;
      t0Flag_q  <= 1'b0;
      ckFlag_q  <= 1'b0;
    end else begin
      // external edge flag, cleared on its vector
      if (pinEdge[0]) begin
        extFlag_q <= 1'b1;
      end else if (take && vecSel_q == vic_pkg::VS_EXT) begin
        extFlag_q <= 1'b0;
      end else if (wrStatus) begin
        extFlag_q <= wByte[vic_pkg::ST_EXTF];
      end
      if (timer0Ovf) begin
        t0Flag_q <= 1'b1;
      end else if (take && vecSel_q == vic_pkg::VS_T0) begin
        t0Flag_q <= 1'b0;
      end else if (wrStatus) begin
        t0Flag_q <= wByte[vic_pkg::ST_T0F];
      end
      if (pinEdge[1]) begin
        ckFlag_q <= 1'b1;
      end else if (take && vecSel_q == vic_pkg::VS_CK) begin
        ckFlag_q <= 1'b0;
      end else if (wrStatus) begin
        ckFlag_q <= wByte[vic_pkg::ST_CKF];
      end
    end
  end

  // ==========================================================
  // Peripheral flags; vectoring never touches them
  // set by events, cleared only by software
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pFlagA_q <= vic_pkg::PA_RST;
      pFlagB_q <= vic_pkg::PB_RST;
    end else begin
      pFlagA_q <= (wrPfA ? wByte : pFlagA_q) | periphEvt[14:7];
      pFlagB_q <= (wrPfB ? wByte[vic_pkg::PB_W-1:0] : pFlagB_q) | periphEvt[6:0];
    end
  end

  // read-only OR of enabled peripheral flags
  assign pendFlag = |{pFlagA_q & pEnA_q, pFlagB_q & pEnB_q};

  // ==========================================================
  // Enable cleared while its flag rises, interrupts on
  // detect the race and remember it
  always_comb begin
    enClrHit = 1'b0;
    if (wrStatus && !gd_q) begin
      enClrHit = (stEn_q[vic_pkg::ST_EXTE] & ~wByte[vic_pkg::ST_EXTE] & pinEdge[0])
               | (stEn_q[vic_pkg::ST_T0E] & ~wByte[vic_pkg::ST_T0E] & timer0Ovf)
               | (stEn_q[vic_pkg::ST_CKE] & ~wByte[vic_pkg::ST_CKE] & pinEdge[1])
               | (stEn_q[vic_pkg::ST_PERIPH_IRQ_ENABLE] & ~wByte[vic_pkg::ST_PERIPH_IRQ_ENABLE] & (|periphEvt));
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      spurious_q <= 1'b0;
    end else if (enClrHit) begin
      spurious_q <= 1'b1;
    end else if (take && vecSel_q == vic_pkg::VS_RESET) begin
      spurious_q <= 1'b0;
    end
  end

  // ==========================================================
  // Request selection
  always_comb begin
    vecSel = vic_pkg::VS_NONE;
    if (!gd_q) begin
      // fixed priority; flag and enable; peripheral gate
      if (spurious_q) begin
        vecSel = vic_pkg::VS_RESET;
      end else if (extFlag_q && stEn_q[vic_pkg::ST_EXTE]) begin
        vecSel = vic_pkg::VS_EXT;
      end else if (t0Flag_q && stEn_q[vic_pkg::ST_T0E]) begin
        vecSel = vic_pkg::VS_T0;
      end else if (ckFlag_q && stEn_q[vic_pkg::ST_CKE]) begin
        vecSel = vic_pkg::VS_CK;
      end else if (pendFlag && stEn_q[vic_pkg::ST_PERIPH_IRQ_ENABLE]) begin
        vecSel = vic_pkg::VS_PER;
      end
    end
  end

  // Registered request; the entry cycle drops it at once
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqReq   <= 1'b0;
      vecSel_q <= vic_pkg::VS_NONE;
    end else if (take) begin
      irqReq   <= 1'b0;
      vecSel_q <= vic_pkg::VS_NONE;
    end else begin
      irqReq   <= (vecSel != vic_pkg::VS_NONE);
      vecSel_q <= vecSel;
    end
  end

  // ==========================================================
  // Global disable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gd_q <= vic_pkg::GD_RST;
    end else if (take) begin
      gd_q <= 1'b1;
    end else if (returnFromIrqInstr) begin
      gd_q <= 1'b0;
    end else if (wrCpu) begin
      gd_q <= wByte[vic_pkg::CS_GD];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      globalIrqDisable <= vic_pkg::GD_RST;
    end else begin
      globalIrqDisable <= take | (gd_q & ~returnFromIrqInstr & ~wrCpu) | (wrCpu & ~returnFromIrqInstr & wByte[vic_pkg::CS_GD]);
    end
  end

  // ==========================================================
  // Return stack; overflow wraps and overwrites the oldest entry
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sp_q <= '0;
    end else if (take) begin
      stack_q[sp_q] <= pcReturn;
      sp_q          <= sp_q + 1'b1;
    end else if (returnFromIrqInstr) begin
      sp_q <= sp_q - 1'b1;
    end
  end

  // ==========================================================
  // Program counter load
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pcLoad <= '0;
    end else if (take) begin
      pcLoad.load <= 1'b1;
      unique case (vecSel_q)
        vic_pkg::VS_EXT:   pcLoad.addr <= vic_pkg::VEC_EXT;
        vic_pkg::VS_T0:    pcLoad.addr <= vic_pkg::VEC_T0;
        vic_pkg::VS_CK:    pcLoad.addr <= vic_pkg::VEC_CK;
        vic_pkg::VS_PER:   pcLoad.addr <= vic_pkg::VEC_PERIPH;
        // spurious entry goes to the reset address
        vic_pkg::VS_RESET: pcLoad.addr <= vic_pkg::VEC_RESET;
        vic_pkg::VS_NONE:  pcLoad.addr <= vic_pkg::VEC_RESET;
      endcase
    end else if (returnFromIrqInstr) begin
      pcLoad.load <= 1'b1;
      pcLoad.addr <= stack_q[sp_q - 1'b1];
    end else begin
      pcLoad.load <= 1'b0;
    end
  end

  // latency: two sync stages, edge, flag, request, then core boundary
  // left to software; hsize unused since only words are mapped

endmodule

/* testbench/vic_irq_ctrl_sva.sv */
// Purpose: Port assertions for the interrupt controller
// Assumes: Core model never nests entries
// Notes:   Bound to every controller instance
`timescale 1ns/10ps
module vic_irq_ctrl_sva (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     nrst,
  // Bus answer
  input wire logic                     hreadyout,
  input wire logic                     hresp,
  // Core link
  input wire logic                     irqAck,
  input wire logic                     returnFromIrqInstr,
  input wire logic [vic_pkg::PC_W-1:0] pcReturn,
  input wire logic                     irqReq,
  input wire vic_pkg::pc_load_s        pcLoad,
  input wire logic                     globalIrqDisable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [vic_pkg::PC_W-1:0] savedPc_q;
  sequence s_entry;
    irqAck && irqReq;
  endsequence
  sequence s_ret;
    returnFromIrqInstr && !(irqAck && irqReq);
  endsequence
  // ==========
  // Return address seen at entry
  always_ff @(posedge clk) begin
    if (irqAck && irqReq) begin
      savedPc_q <= pcReturn;
    end
  end
  a_entry_load: assert property (s_entry |=> pcLoad.load && !irqReq)
    else $error("entry without vector load");
  a_entry_disable: assert property (s_entry |=> globalIrqDisable)
    else $error("entry left interrupts enabled");
  a_vector_legal: assert property (s_entry |=> pcLoad.addr inside {16'h0000, 16'h0008, 16'h0010, 16'h0018, 16'h0020})
    else $error("entry to an unknown vector");
  a_disable_blocks: assert property (globalIrqDisable && $past(globalIrqDisable) |-> !irqReq)
    else $error("request while globally disabled");
  a_ret_pop: assert property (s_ret |=> pcLoad.load && pcLoad.addr == savedPc_q)
    else $error("return did not pop address");
  a_ret_enable: assert property (s_ret |=> !globalIrqDisable)
    else $error("return left interrupts disabled");
  a_load_cause: assert property (pcLoad.load |-> ($past(irqAck) && $past(irqReq)) || $past(returnFromIrqInstr))
    else $error("vector load without cause");
  a_idle_no_load: assert property (!(irqAck && irqReq) && !returnFromIrqInstr |=> !pcLoad.load)
    else $error("pc loaded without entry or return");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
endmodule

bind vic_irq_ctrl vic_irq_ctrl_sva u_sva (
  .clk(clk), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp), .irqAck(irqAck),
  .returnFromIrqInstr(returnFromIrqInstr), .pcReturn(pcReturn), .irqReq(irqReq),
  .pcLoad(pcLoad), .globalIrqDisable(globalIrqDisable)
);

/* testbench/vic_core_model.sv */
// Purpose: Core sequencer facing the controller
// Assumes: Acks only on instruction boundaries
// Notes:   Slow mode stands for two-cycle instructions
`timescale 1ns/10ps
module vic_core_model (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // Bench control
  input  wire logic                     slowMode,
  input  wire logic                     retGo,
  // Controller link
  input  wire logic                     irqReq,
  input  wire vic_pkg::pc_load_s        pcLoad,
  output logic                          irqAck,
  output logic                          returnFromIrqInstr,
  output logic [vic_pkg::PC_W-1:0]      pcReturn
);
  logic                    phase_q;
  logic [vic_pkg::PC_W-1:0] pc_q;
  assign irqAck = irqReq && (!slowMode || phase_q);
  assign returnFromIrqInstr = retGo;
  assign pcReturn = pc_q;
  // ==========
  // Program counter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_q <= 1'b0;
      pc_q <= 16'h0100;
    end else begin
      phase_q <= !phase_q;
      pc_q <= pcLoad.load ? pcLoad.addr : pc_q + 16'h0001;
    end
  end
endmodule

/* testbench/vic_irq_ctrl_test.sv */
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Core model acks at once or every other cycle
// Notes:   Vectors and return addresses queue up as notes
`timescale 1ns/10ps
module vic_irq_ctrl_test;
  logic                clk = 1'b0;
  logic                nrst = 1'b0;
  logic [31:0]         haddr = 32'h0;
  logic [1:0]          htrans = 2'h0;
  logic                hwrite = 1'b0;
  logic [31:0]         hwdata = 32'h0;
  logic                extIrqPin = 1'b0;
  logic                timerClockPin = 1'b0;
  logic                timer0Ovf = 1'b0;
  vic_pkg::periph_evt_s periphEvt = '0;
  logic                slowMode = 1'b0;
  logic                retGo = 1'b0;
  logic                spur = 1'b0;
  logic                rdPh = 1'b0;
  logic                hreadyout, hresp, irqReq, irqAck, retIns, gdOut, pnd;
  logic [31:0]         hrdata;
  logic [15:0]         pcRet, retAddr;
  vic_pkg::pc_load_s   pcLoad;
  logic [15:0]         ldQ[$];
  logic [31:0]         rdQ[$];
  logic [31:0]         rng = 32'hC29C0A0A;
  logic [15:0]         vecs[4] = '{vic_pkg::VEC_EXT, vic_pkg::VEC_T0, vic_pkg::VEC_CK, vic_pkg::VEC_PERIPH};
  int                  num_errors = 0;
  int                  tests_run = 0;
  int                  nLoads = 0;

  always #12.5 clk = ~clk;

  vic_irq_ctrl u_dut (
    .clk(clk), .nrst(nrst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .extIrqPin(extIrqPin), .timerClockPin(timerClockPin), .timer0Ovf(timer0Ovf),
    .periphEvt(periphEvt), .irqAck(irqAck), .returnFromIrqInstr(retIns), .pcReturn(pcRet),
    .irqReq(irqReq), .pcLoad(pcLoad), .globalIrqDisable(gdOut)
  );
  vic_core_model u_core (
    .clk(clk), .nrst(nrst), .slowMode(slowMode), .retGo(retGo), .irqReq(irqReq), .pcLoad(pcLoad),
    .irqAck(irqAck), .returnFromIrqInstr(retIns), .pcReturn(pcRet)
  );

  // ==========
  // Helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    haddr <= {22'h0, idx, 2'h0};
    htrans <= vic_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    if (spur) timer0Ovf <= 1'b1;
    if (!wr) rdQ.push_back({24'h0, d});
    do @(posedge clk); while (hreadyout !== 1'b1);
    if (spur) timer0Ovf <= 1'b0;
  endtask
  task automatic wait_load(input int n);
    int t;
    t = 0;
    while (nLoads < n && t < 60) begin
      @(posedge clk);
      t++;
    end
    if (nLoads < n) chk("loadCount", nLoads, n);
    @(posedge clk);
  endtask
  task automatic fire(input logic [3:0] m);
    extIrqPin <= m[0];
    timer0Ovf <= m[1];
    timerClockPin <= m[2];
    periphEvt <= m[3] ? 15'h0080 : 15'h0000;
    @(posedge clk);
    timer0Ovf <= 1'b0;
    periphEvt <= '0;
    repeat (3) @(posedge clk);
    extIrqPin <= 1'b0;
    timerClockPin <= 1'b0;
  endtask
  task automatic ret(input logic more, input logic [15:0] v);
    ldQ.push_back(retAddr);
    if (more) ldQ.push_back(v);
    retGo <= 1'b1;
    @(posedge clk);
    retGo <= 1'b0;
    wait_load(nLoads + 1 + int'(more));
  endtask

  // ==========
  // Result watcher
  always @(posedge clk) begin
    if (rdPh && hreadyout === 1'b1) chk("hrdata", hrdata, rdQ.pop_front());
    rdPh <= htrans == vic_pkg::HTRANS_NONSEQ && !hwrite && hreadyout === 1'b1;
    if (pcLoad.load === 1'b1) begin
      chk("pcLoad", {16'h0, pcLoad.addr}, {16'h0, ldQ.pop_front()});
      nLoads++;
    end
    if (irqAck === 1'b1 && irqReq === 1'b1) retAddr = pcRet;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end

  // ==========
  // Scenarios
  initial begin
    int tgt;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    ahb(1, 8'h3F, 8'hFF);
    ahb(0, 8'h3F, 8'h00);
    ahb(0, vic_pkg::IDX_CPU_STATUS, 8'h13);
    ahb(0, vic_pkg::IDX_IRQ_STATUS, 8'h00);
    ahb(0, vic_pkg::IDX_PENABLE_A, 8'h00);
    ahb(0, vic_pkg::IDX_PENABLE_B, 8'h00);
    repeat (4) begin
      rng = nxt(rng);
      ahb(1, vic_pkg::IDX_PENABLE_A, rng[7:0]);
      ahb(1, vic_pkg::IDX_PENABLE_B, {1'b0, rng[14:8]});
      periphEvt <= rng[29:15];
      @(posedge clk);
      periphEvt <= '0;
      pnd = |(rng[29:22] & rng[7:0]) | |(rng[21:15] & rng[14:8]);
      ahb(0, vic_pkg::IDX_PFLAG_A, rng[29:22]);
      ahb(0, vic_pkg::IDX_PFLAG_B, {1'b0, rng[21:15]});
      ahb(0, vic_pkg::IDX_PENABLE_B, {1'b0, rng[14:8]});
      ahb(0, vic_pkg::IDX_IRQ_STATUS, {pnd, 7'h0});
      ahb(1, vic_pkg::IDX_PFLAG_A, 8'h00);
      ahb(1, vic_pkg::IDX_PFLAG_B, 8'h00);
    end
    for (int k = 0; k < 4; k++) begin
      slowMode <= k[0];
      ahb(1, vic_pkg::IDX_PENABLE_A, 8'h01);
      ahb(1, vic_pkg::IDX_IRQ_STATUS, 8'h01 << k);
      ahb(1, vic_pkg::IDX_CPU_STATUS, 8'h03);
      ldQ.push_back(vecs[k]);
      // Target fixed first; a fast entry may land as fire returns
      tgt = nLoads + 1;
      fire(4'h1 << k);
      wait_load(tgt);
      ahb(0, vic_pkg::IDX_IRQ_STATUS, (k == 3) ? 8'h88 : (8'h01 << k));
      if (k == 3) ahb(1, vic_pkg::IDX_PFLAG_A, 8'h00);
      ret(1'b0, 16'h0);
      ahb(1, vic_pkg::IDX_CPU_STATUS, 8'h13);
    end
    ahb(1, vic_pkg::IDX_IRQ_STATUS, 8'h0F);
    fire(4'hF);
    ldQ.push_back(vic_pkg::VEC_EXT);
    ahb(1, vic_pkg::IDX_CPU_STATUS, 8'h03);
    wait_load(nLoads + 1);
    ret(1'b1, vic_pkg::VEC_T0);
    ret(1'b1, vic_pkg::VEC_CK);
    ret(1'b1, vic_pkg::VEC_PERIPH);
    ahb(1, vic_pkg::IDX_PFLAG_A, 8'h00);
    ret(1'b0, 16'h0);
    ahb(1, vic_pkg::IDX_IRQ_STATUS, 8'h02);
    spur = 1'b1;
    ldQ.push_back(vic_pkg::VEC_RESET);
    ahb(1, vic_pkg::IDX_IRQ_STATUS, 8'h00);
    spur = 1'b0;
    wait_load(nLoads + 1);
    ret(1'b0, 16'h0);
    ahb(1, vic_pkg::IDX_CPU_STATUS, 8'h13);
    ahb(1, vic_pkg::IDX_CPU_STATUS, 8'h11);
    ahb(0, vic_pkg::IDX_CPU_STATUS, 8'h11);
    fire(4'h1);
    repeat (4) @(posedge clk);
    ahb(0, vic_pkg::IDX_IRQ_STATUS, 8'h30);
    chk("ldQ", ldQ.size(), 0);
    close_out();
  end
endmodule
